// ==== common/rrsse_pkg.sv ====
// constants and types for the return/rotate/sleep/subtract executor
package rrsse_pkg;

  // ==========================================================
  // widths
  localparam int INSTR_W = 14;
  localparam int PC_W    = 13;
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 7;
  localparam int BUS_AW  = 8;

  // ==========================================================
  // opcode patterns and masks
  localparam logic [13:0] OP_LITRET_MASK = 14'h3c00;
  localparam logic [13:0] OP_LITRET_PAT  = 14'h3400;
  localparam logic [13:0] OP_RETURN      = 14'h0008;
  localparam logic [13:0] OP_FILE_MASK   = 14'h3f00;
  localparam logic [13:0] OP_ROTR_PAT    = 14'h0c00;
  localparam logic [13:0] OP_ROTL_PAT    = 14'h0d00;
  localparam logic [13:0] OP_FSUB_PAT    = 14'h0200;
  localparam logic [13:0] OP_SLEEP       = 14'h0063;
  localparam logic [13:0] OP_LITSUB_MASK = 14'h3e00;
  localparam logic [13:0] OP_LITSUB_PAT  = 14'h3c00;
  localparam int          DEST_BIT      = 7;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] REG_ACC    = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_EXEC   = 8'h08;

  // status field positions
  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;

  // exec field positions
  localparam int EX_READY = 0;
  localparam int EX_SLEEP = 1;

  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic       PD_RST  = 1'b1;
  localparam logic       TO_RST  = 1'b1;

  // ==========================================================
  // types
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_DRAIN, ST_SLEEP}
    rrsse_state_t;
  typedef enum logic [1:0] {FOP_RR, FOP_RL, FOP_SUB} rrsse_fop_t;

endpackage

// ==== design/rrsse_exec.sv ====
// executor for return, rotate, sleep and subtract opcodes
// Notes on behaviour
// - return-literal loads immediate into accumulator, flags kept
// - return-literal pops stack to PC, two cycles
// - return pops stack to PC, flags kept, two cycles
// - rotate right through carry, only carry changes
// - destination bit zero to accumulator, one to file
// - rotate left through carry, only carry changes
// - sleep clears power-down flag, sets timeout flag
// - sleep clears watchdog counter
// - after sleep core stops oscillator until wake
// - literal minus accumulator into accumulator, C DC Z
// - file minus accumulator, routed by destination, C DC Z
// - carry set means no borrow after subtract
module rrsse_exec
  import rrsse_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  // instruction in
  input  wire logic [INSTR_W-1:0]   instr,
  input  wire logic                 instr_valid,
  output logic                      instr_ready,
  // data register file
  output logic [FADDR_W-1:0]        file_addr,
  input  wire logic [DATA_W-1:0]    file_rdata,
  output logic [DATA_W-1:0]         file_wdata,
  output logic                      file_we,
  // return stack and program counter
  input  wire logic [PC_W-1:0]      stack_top,
  output logic                      stack_pop,
  output logic                      pc_load,
  output logic [PC_W-1:0]           pc_value,
  // power management
  output logic                      watchdog_counter_clear,
  output logic                      osc_stop,
  input  wire logic                 wake_pin,
  // flags and accumulator
  output logic [DATA_W-1:0]         acc,
  output logic                      carry_flag,
  output logic                      digit_carry_flag,
  output logic                      zero_flag,
  output logic                      power_down_flag,
  output logic                      timeout_flag,
  // register port
  input  wire logic [BUS_AW-1:0]    reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata
);

  // ==========================================================
  // state
  typedef struct packed {
    rrsse_state_t         st;
    rrsse_fop_t           fop;
    logic                 fdest;
    logic [FADDR_W-1:0]   faddr;
    logic [DATA_W-1:0]    acc;
    logic                 c;
    logic                 dc;
    logic                 z;
    logic                 pd;
    logic                 to;
    logic [DATA_W-1:0]    fwdata;
    logic                 fwe;
    logic                 pop;
    logic                 pcld;
    logic [PC_W-1:0]      pcv;
    logic                 wdclr;
    logic                 sleep;
    logic                 ready;
    logic [31:0]          rdata;
    logic                 wake_s1;
    logic                 wake_s2;
  } rrsse_q_t;

  rrsse_q_t q_r;
  rrsse_q_t q_nxt;

  logic                 go;
  logic [DATA_W-1:0]    lit;
  logic [DATA_W-1:0]    sub_a;
  logic [DATA_W:0]      sub_sum;
  logic [4:0]           nib_sum;
  logic [DATA_W-1:0]    res;
  logic                 res_c;

  assign go  = q_r.ready && instr_valid;
  assign lit = instr[DATA_W-1:0];

  // ==========================================================
  // datapath
  always_comb
  begin
    // two's complement: a + ~w + 1, carry out is the no-borrow flag
    sub_a = (q_r.st == ST_FETCH) ? file_rdata : lit;
    sub_sum = {1'b0, sub_a} + {1'b0, ~q_r.acc} + 9'h001;
    nib_sum = {1'b0, sub_a[3:0]} + {1'b0, ~q_r.acc[3:0]} + 5'h01;
    case (q_r.fop)
      FOP_RR:
      begin
        res   = {q_r.c, file_rdata[DATA_W-1:1]};
        res_c = file_rdata[0];
      end
      FOP_RL:
      begin
        res   = {file_rdata[DATA_W-2:0], q_r.c};
        res_c = file_rdata[DATA_W-1];
      end
      default:
      begin
        res   = sub_sum[DATA_W-1:0];
        res_c = sub_sum[DATA_W];
      end
    endcase
  end

  // ==========================================================
  // control
  always_comb
  begin
    q_nxt       = q_r;
    q_nxt.fwe   = 1'b0;
    q_nxt.pop   = 1'b0;
    q_nxt.pcld  = 1'b0;
    q_nxt.wdclr = 1'b0;
    q_nxt.rdata = 32'h0000_0000;
    // wake input crosses in through two flops
    q_nxt.wake_s1 = wake_pin;
    q_nxt.wake_s2 = q_r.wake_s1;

    // software access first; execution below overrides it
    if (reg_wr)
    begin
      if (reg_addr == REG_ACC)
        q_nxt.acc = reg_wdata[DATA_W-1:0];
      else if (reg_addr == REG_STATUS)
      begin
        q_nxt.c  = reg_wdata[ST_C];
        q_nxt.dc = reg_wdata[ST_DC];
        q_nxt.z  = reg_wdata[ST_Z];
      end
    end
    if (reg_rd)
    begin
      case (reg_addr)
        REG_ACC:    q_nxt.rdata = {24'h00_0000, q_r.acc};
        REG_STATUS: q_nxt.rdata = {27'h000_0000, q_r.to, q_r.pd,
                                   q_r.z, q_r.dc, q_r.c};
        REG_EXEC:   q_nxt.rdata = {30'h0000_0000, q_r.sleep, q_r.ready};
        default:    q_nxt.rdata = 32'h0000_0000;
      endcase
    end

    case (q_r.st)
      ST_IDLE:
      begin
        if (go)
        begin
          if ((instr & OP_LITRET_MASK) == OP_LITRET_PAT)
          begin
            q_nxt.acc   = lit;
            q_nxt.pop   = 1'b1;
            q_nxt.pcld  = 1'b1;
            q_nxt.pcv   = stack_top;
            q_nxt.ready = 1'b0;
            q_nxt.st    = ST_DRAIN;
          end
          else if (instr == OP_RETURN)
          begin
            q_nxt.pop   = 1'b1;
            q_nxt.pcld  = 1'b1;
            q_nxt.pcv   = stack_top;
            q_nxt.ready = 1'b0;
            q_nxt.st    = ST_DRAIN;
          end
          else if ((instr & OP_LITSUB_MASK) == OP_LITSUB_PAT)
          begin
            q_nxt.acc = sub_sum[DATA_W-1:0];
            q_nxt.c   = sub_sum[DATA_W];
            q_nxt.dc  = nib_sum[4];
            q_nxt.z   = (sub_sum[DATA_W-1:0] == 8'h00);
          end
          else if (instr == OP_SLEEP)
          begin
            q_nxt.pd    = 1'b0;
            q_nxt.to    = 1'b1;
            q_nxt.wdclr = 1'b1;
            q_nxt.sleep = 1'b1;
            q_nxt.ready = 1'b0;
            q_nxt.st    = ST_SLEEP;
          end
          else if (((instr & OP_FILE_MASK) == OP_ROTR_PAT) ||
                   ((instr & OP_FILE_MASK) == OP_ROTL_PAT) ||
                   ((instr & OP_FILE_MASK) == OP_FSUB_PAT))
          begin
            q_nxt.faddr = instr[FADDR_W-1:0];
            q_nxt.fdest = instr[DEST_BIT];
            if ((instr & OP_FILE_MASK) == OP_ROTR_PAT)
              q_nxt.fop = FOP_RR;
            else if ((instr & OP_FILE_MASK) == OP_ROTL_PAT)
              q_nxt.fop = FOP_RL;
            else
              q_nxt.fop = FOP_SUB;
            q_nxt.ready = 1'b0;
            q_nxt.st    = ST_FETCH;
          end
        end
      end
      ST_FETCH:
      begin
        // operand is read in the same clock that the address goes out
        if (q_r.fdest)
        begin
          q_nxt.fwdata = res;
          q_nxt.fwe    = 1'b1;
        end
        else
          q_nxt.acc = res;
        q_nxt.c = res_c;
        if (q_r.fop == FOP_SUB)
        begin
          q_nxt.dc = nib_sum[4];
          q_nxt.z  = (res == 8'h00);
        end
        q_nxt.ready = 1'b1;
        q_nxt.st    = ST_IDLE;
      end
      ST_DRAIN:
      begin
        // second instruction cycle of a return
        q_nxt.ready = 1'b1;
        q_nxt.st    = ST_IDLE;
      end
      ST_SLEEP:
      begin
        // oscillator request held until the synchronised wake
        if (q_r.wake_s2)
        begin
          q_nxt.sleep = 1'b0;
          q_nxt.ready = 1'b1;
          q_nxt.st    = ST_IDLE;
        end
      end
      default:
      begin
        q_nxt.ready = 1'b1;
        q_nxt.st    = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      q_r       <= '0;
      q_r.st    <= ST_IDLE;
      q_r.fop   <= FOP_RR;
      q_r.acc   <= ACC_RST;
      q_r.pd    <= PD_RST;
      q_r.to    <= TO_RST;
      q_r.ready <= 1'b1;
    end
    else
      q_r <= q_nxt;
  end

  // ==========================================================
  // outputs
  assign instr_ready            = q_r.ready;
  assign file_addr              = q_r.faddr;
  assign file_wdata             = q_r.fwdata;
  assign file_we                = q_r.fwe;
  assign stack_pop              = q_r.pop;
  assign pc_load                = q_r.pcld;
  assign pc_value               = q_r.pcv;
  assign watchdog_counter_clear = q_r.wdclr;
  assign osc_stop               = q_r.sleep;
  assign acc                    = q_r.acc;
  assign carry_flag             = q_r.c;
  assign digit_carry_flag       = q_r.dc;
  assign zero_flag              = q_r.z;
  assign power_down_flag        = q_r.pd;
  assign timeout_flag           = q_r.to;
  assign reg_rdata              = q_r.rdata;

  // ==========================================================
  // checks
  logic dec_litret;
  logic dec_litsub;
  assign dec_litret = (instr & OP_LITRET_MASK) == OP_LITRET_PAT;
  assign dec_litsub = (instr & OP_LITSUB_MASK) == OP_LITSUB_PAT;

  default clocking chk_cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  lit_return_a: assert property (
    go && dec_litret && !reg_wr |=> acc == $past(lit) &&
      $stable({q_r.c, q_r.dc, q_r.z}))
    else $error("literal return did not load accumulator");

  return_pop_a: assert property (
    go && (dec_litret || instr == OP_RETURN) |=>
      stack_pop && pc_load && pc_value == $past(stack_top) && !instr_ready
      ##1 !stack_pop && instr_ready)
    else $error("return did not pop in two cycles");

  return_flags_a: assert property (
    go && instr == OP_RETURN && !reg_wr |=> $stable(acc) &&
      $stable({q_r.c, q_r.dc, q_r.z, q_r.pd, q_r.to}))
    else $error("return changed accumulator or flags");

  rotate_right_a: assert property (
    q_r.st == ST_FETCH && q_r.fop == FOP_RR |=>
      carry_flag == $past(file_rdata[0]) && $stable(zero_flag) &&
      (file_we ? file_wdata : acc) == {$past(q_r.c), $past(file_rdata[7:1])})
    else $error("rotate right result wrong");

  rotate_left_a: assert property (
    q_r.st == ST_FETCH && q_r.fop == FOP_RL |=>
      carry_flag == $past(file_rdata[7]) && $stable(digit_carry_flag) &&
      (file_we ? file_wdata : acc) == {$past(file_rdata[6:0]), $past(q_r.c)})
    else $error("rotate left result wrong");

  dest_route_a: assert property (
    q_r.st == ST_FETCH |=> file_we == $past(q_r.fdest))
    else $error("destination routing wrong");

  sleep_flags_a: assert property (
    go && instr == OP_SLEEP |=> !power_down_flag && timeout_flag &&
      watchdog_counter_clear && osc_stop ##1 !watchdog_counter_clear)
    else $error("sleep flags or watchdog clear wrong");

  sleep_hold_a: assert property (
    osc_stop && !q_r.wake_s2 |=> osc_stop && !instr_ready)
    else $error("sleep left without wake");

  lit_sub_a: assert property (
    go && dec_litsub |=> acc == 8'($past(lit) - $past(acc)) &&
      carry_flag == ($past(lit) >= $past(acc)) &&
      zero_flag == ($past(lit) == $past(acc)) && instr_ready)
    else $error("literal subtract wrong");

  file_sub_a: assert property (
    q_r.st == ST_FETCH && q_r.fop == FOP_SUB |=>
      carry_flag == ($past(file_rdata) >= $past(q_r.acc)) &&
      digit_carry_flag ==
        ($past(file_rdata[3:0]) >= $past(q_r.acc[3:0])))
    else $error("file subtract flags wrong");

  file_addr_a: assert property (
    go && (instr & OP_FILE_MASK) == OP_FSUB_PAT |=>
      file_addr == $past(instr[6:0]) && q_r.st == ST_FETCH)
    else $error("file address not taken from opcode");

endmodule

// ==== verification/rrsse_exec_tb_top.sv ====
// self-checking bench for the return/rotate/sleep/subtract executor
module rrsse_exec_tb_top
  import rrsse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic        instr_valid = 1'b0;
  logic        wake_pin = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        instr_ready, file_we, stack_pop, pc_load, osc_stop;
  logic        watchdog_counter_clear, carry_flag, digit_carry_flag;
  logic        zero_flag, power_down_flag, timeout_flag;
  logic [6:0]  file_addr;
  logic [7:0]  file_rdata, file_wdata, acc;
  logic [12:0] stack_top, pc_value;
  logic [31:0] reg_rdata;
  int          bad_count = 0;
  int          checks_done = 0;
  logic [7:0]  mem_m [128];
  logic [7:0]  acc_m = 8'h00;
  logic [4:0]  st_m = 5'h18;
  int          pops_m = 0;

  always #4 clk_sys = ~clk_sys;

  rrsse_exec rrsse_exec_inst (.clk_sys, .rstn, .instr, .instr_valid,
    .instr_ready, .file_addr, .file_rdata, .file_wdata, .file_we,
    .stack_top, .stack_pop, .pc_load, .pc_value, .watchdog_counter_clear,
    .osc_stop, .wake_pin, .acc, .carry_flag, .digit_carry_flag,
    .zero_flag, .power_down_flag, .timeout_flag, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata);

  rrsse_partner rrsse_partner_inst (.clk_sys, .file_addr, .file_rdata,
    .file_wdata, .file_we, .stack_top, .stack_pop);

  // ==========================================================
  // checking and model
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_state();
    chk("acc", 32'(acc_m), 32'(acc));
    chk("status", 32'(st_m), 32'({timeout_flag, power_down_flag,
      zero_flag, digit_carry_flag, carry_flag}));
  endtask

  // st_m is {timeout, power down, zero, digit carry, carry}
  function automatic logic [7:0] sub_m(logic [7:0] a, logic [7:0] b);
    st_m[2:0] = {a - b == 8'h00, a[3:0] >= b[3:0], a >= b};
    return a - b;
  endfunction

  task automatic report_and_stop();
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // drivers
  task automatic reg_io(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask

  task automatic issue(logic [13:0] op);
    @(posedge clk_sys);
    instr <= op;
    instr_valid <= 1'b1;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic do_ret(logic [13:0] op);
    logic [12:0] top_m;
    top_m = 13'(pops_m * 291 + 17);
    issue(op);
    pops_m++;
    if (op[13])
      acc_m = op[7:0];
    chk("pop", 32'h3, 32'({stack_pop, pc_load}));
    chk("pc", 32'(top_m), 32'(pc_value));
    chk("busy", 32'h0, 32'(instr_ready));
    chk_state();
    @(posedge clk_sys);
    #1;
    chk("done", 32'h1, 32'({stack_pop, pc_load, instr_ready}));
  endtask

  task automatic do_file(logic [13:0] op);
    logic [7:0] f, r;
    f = mem_m[op[6:0]];
    r = op[8] ? {f[6:0], st_m[0]} : {st_m[0], f[7:1]};
    if (op[11])
      st_m[0] = op[8] ? f[7] : f[0];
    else
      r = sub_m(f, acc_m);
    issue(op);
    chk("addr", 32'(op[6:0]), 32'(file_addr));
    @(posedge clk_sys);
    #1;
    chk("we", 32'(op[7]), 32'(file_we));
    if (op[7])
      chk("wdata", 32'(r), 32'(file_wdata));
    if (op[7])
      mem_m[op[6:0]] = r;
    else
      acc_m = r;
    chk_state();
    chk("ready", 32'h1, 32'(instr_ready));
  endtask

  // literal subtracts and ignored opcodes offered every cycle
  task automatic stream(int cnt);
    logic [13:0] op, nxt;
    op = 14'h0000;
    for (int i = 0; i <= cnt; i++)
    begin
      @(posedge clk_sys);
      nxt = ($urandom % 3 == 0) ? 14'h0000
          : {5'h1e, 1'($urandom), 8'($urandom)};
      instr <= nxt;
      instr_valid <= 1'(i < cnt);
      #1;
      if (i > 0 && op[13])
        acc_m = sub_m(op[7:0], acc_m);
      if (i > 0)
        chk_state();
      op = nxt;
    end
  endtask

  task automatic do_sleep();
    int n;
    issue(OP_SLEEP);
    st_m[4:3] = 2'b10;
    chk_state();
    chk("wdc", 32'h3, 32'({watchdog_counter_clear, osc_stop}));
    @(posedge clk_sys);
    instr <= 14'h3c55;
    instr_valid <= 1'b1;
    repeat (20) @(posedge clk_sys);
    instr_valid <= 1'b0;
    wake_pin <= 1'b1;
    #1;
    chk("hold", 32'h2, 32'({instr_ready, osc_stop,
      watchdog_counter_clear}));
    chk_state();
    n = 0;
    while (instr_ready !== 1'b1 && n < 10)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("wake", 32'd3, 32'(n));
    chk("osc", 32'h0, 32'(osc_stop));
    @(posedge clk_sys);
    wake_pin <= 1'b0;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] v;
    void'($urandom(75066));
    for (int i = 0; i < 128; i++)
      mem_m[i] = 8'(i * 37 + 5);
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    #1;
    chk_state();
    reg_io(1'b0, REG_EXEC, 32'h0);
    chk("exec", 32'h1, reg_rdata);
    reg_io(1'b1, 8'h0c, 32'hff);
    reg_io(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h0, reg_rdata);
    for (int i = 0; i < 6; i++)
    begin
      v = $urandom;
      reg_io(1'b1, REG_ACC, v);
      acc_m = v[7:0];
      reg_io(1'b1, REG_STATUS, v >> 8);
      st_m[2:0] = v[10:8];
      reg_io(1'b0, REG_STATUS, 32'h0);
      chk("status_rd", 32'(st_m), reg_rdata);
      do_file({6'h0c, 1'(i), 7'($urandom)});
      do_file({6'h0d, 1'(i), 7'($urandom)});
      do_file({6'h02, 1'(i), 7'($urandom)});
      do_ret({4'hd, 2'($urandom), 8'($urandom)});
      do_ret(OP_RETURN);
      stream(8);
    end
    do_sleep();
    reg_io(1'b0, REG_ACC, 32'h0);
    chk("acc_rd", 32'(acc_m), reg_rdata);
    report_and_stop();
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    bad_count++;
    report_and_stop();
  end
endmodule

// ==== verification/rrsse_partner.sv ====
// far-side model: data register file and return stack
module rrsse_partner
  import rrsse_pkg::*;
(
  // clock
  input  wire logic               clk_sys,
  // register file
  input  wire logic [FADDR_W-1:0] file_addr,
  output logic      [DATA_W-1:0]  file_rdata,
  input  wire logic [DATA_W-1:0]  file_wdata,
  input  wire logic               file_we,
  // return stack
  output logic      [PC_W-1:0]    stack_top,
  input  wire logic               stack_pop
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [DATA_W-1:0] mem [128];
  int                pops = 0;

  // ==========================================================
  // contents
  // same seeding as the bench model so both agree without a backdoor
  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 8'(i * 37 + 5);
  end

  assign file_rdata = mem[file_addr];
  assign stack_top  = 13'(pops * 291 + 17);

  always @(posedge clk_sys)
  begin
    if (file_we)
      mem[file_addr] <= file_wdata;
    if (stack_pop)
      pops <= pops + 1;
  end
endmodule
